// *** hdl/mbp_pwm_timer.sv ***
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "mbp_defs.svh"
module mbp_pwm_timer import mbp_pkg::*; #(
  parameter int NCAP = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NCAP-1:0] cap_i,
  output logic [`MBP_NUM_OUT-1:0] pwm_o
);
  localparam int NM = `MBP_NUM_MATCH;
  localparam int NO = `MBP_NUM_OUT;
  localparam int CSW = (NCAP > 1) ? $clog2(NCAP) : 1;

  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [NM-1:0] iflag_r, iflag_nxt;
  logic [3:0] tctl_r, tctl_nxt;
  logic [31:0] tc_r, tc_nxt, plim_r, plim_nxt, pc_r, pc_nxt;
  mbp_mact_t [NM-1:0] mact_r, mact_nxt;
  logic [31:0] mr_shd_r [NM];
  logic [31:0] mr_shd_nxt [NM];
  logic [31:0] mr_act_r [NM];
  logic [31:0] mr_act_nxt [NM];
  mbp_cmode_t cmode_r, cmode_nxt;
  logic [CSW-1:0] csel_r, csel_nxt;
  logic [NO:2] dbl_r, dbl_nxt;
  logic [NO-1:0] oe_r, oe_nxt;
  logic [NM-1:0] rel_r, rel_nxt;
  logic [NO-1:0] pwm_r, pwm_nxt;

  logic bus_req, bus_wr, tc_wr, cnt_ev, run_w, pwm_on, tick, rst_hit, stop_hit;
  logic [NM-1:0] match_w, irq_v, rst_v, stop_v;
  logic [NO-1:0] lvl_w;
  logic [NO:0] dbl_all;
  logic [31:0] wval, rval;
  int widx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // Returns the match register index for an address, or -1 outside that window or off a word boundary.
  function automatic int mr_index(input logic [7:0] adr);
    int off;
    off = int'(adr) - int'(`MBP_OFF_MR0);
    if (off >= 0 && off < 4 * NM && adr[1:0] == 2'b00) begin
      return off / 4;
    end
    return -1;
  endfunction

  mbp_cnt_src #(
    .NCAP(NCAP),
    .CSW(CSW)
  ) mbp_cnt_src_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cap_i(cap_i),
    .mode_i(cmode_r),
    .sel_i(csel_r),
    .cnt_ev_o(cnt_ev)
  );

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr = bus_req & wb_we_i;
  assign tc_wr = bus_wr && (wb_adr_i == `MBP_OFF_TC);
  assign widx = mr_index(wb_adr_i);
  assign run_w = tctl_r[`MBP_TCTL_EN] & ~tctl_r[`MBP_TCTL_RST];
  assign pwm_on = tctl_r[`MBP_TCTL_PWM];
  assign tick = run_w & cnt_ev & (pc_r == plim_r);

  always_comb begin
    for (int i = 0; i < NM; i++) begin
      match_w[i] = tick & (tc_r == mr_act_r[i]);
      irq_v[i] = mact_r[i].irq;
      rst_v[i] = mact_r[i].rst;
      stop_v[i] = mact_r[i].stop;
    end
  end

  // In PWM mode match zero always restarts the cycle.
  assign rst_hit = |(match_w & rst_v) | (pwm_on & match_w[0]);
  assign stop_hit = |(match_w & stop_v);
  assign dbl_all = {dbl_r, 2'b00};

  for (genvar k = 1; k <= NO; k++) begin : g_chan
    mbp_pwm_chan mbp_pwm_chan_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(pwm_on),
      .period_ev_i(match_w[0]),
      .set_ev_i(match_w[k-1]),
      .clr_ev_i(match_w[k]),
      .own_zero_i(mr_act_r[k] == 32'h0),
      .dbl_i(dbl_all[k]),
      .level_o(lvl_w[k-1])
    );
  end

  always_comb begin
    rval = 32'h0;
    case (wb_adr_i)
      `MBP_OFF_IFLAG: rval[NM-1:0] = iflag_r;
      `MBP_OFF_TCTL: rval[3:0] = tctl_r;
      `MBP_OFF_TC: rval = tc_r;
      `MBP_OFF_PLIM: rval = plim_r;
      `MBP_OFF_PCNT: rval = pc_r;
      `MBP_OFF_MCTL: rval[3*NM-1:0] = mact_r;
      `MBP_OFF_CCTL: begin
        rval[`MBP_CCTL_MODE +: 2] = cmode_r;
        rval[`MBP_CCTL_SEL +: CSW] = csel_r;
      end
      `MBP_OFF_PCTL: begin
        rval[`MBP_PCTL_DBL +: NO-1] = dbl_r;
        rval[`MBP_PCTL_OE +: NO] = oe_r;
      end
      `MBP_OFF_REL: rval[NM-1:0] = rel_r;
      default: begin
        if (widx >= 0) begin
          rval = mr_shd_r[widx];
        end
      end
    endcase
  end

  always_comb begin
    ack_nxt = bus_req;
    rdat_nxt = rdat_r;
    iflag_nxt = iflag_r;
    tctl_nxt = tctl_r;
    tc_nxt = tc_r;
    plim_nxt = plim_r;
    pc_nxt = pc_r;
    mact_nxt = mact_r;
    cmode_nxt = cmode_r;
    csel_nxt = csel_r;
    dbl_nxt = dbl_r;
    oe_nxt = oe_r;
    rel_nxt = rel_r;
    mr_shd_nxt = mr_shd_r;
    mr_act_nxt = mr_act_r;
    wval = 32'h0;
    if (run_w && cnt_ev) begin
      pc_nxt = (pc_r == plim_r) ? 32'h0 : pc_r + 32'h1;
    end
    if (tick) begin
      tc_nxt = rst_hit ? 32'h0 : tc_r + 32'h1;
    end
    if (rst_hit) begin
      pc_nxt = 32'h0;
    end
    // Timer mode uses a written value at once; PWM mode waits for its release bit and then the cycle start.
    for (int i = 0; i < NM; i++) begin
      if (!pwm_on) begin
        mr_act_nxt[i] = mr_shd_r[i];
        rel_nxt[i] = 1'b0;
      end else if (match_w[0] && rel_r[i]) begin
        mr_act_nxt[i] = mr_shd_r[i];
        rel_nxt[i] = 1'b0;
      end
    end
    if (bus_req && !wb_we_i) begin
      rdat_nxt = rval;
    end
    if (bus_wr) begin
      wval = merge(rval, wb_dat_i, wb_sel_i);
      case (wb_adr_i)
        `MBP_OFF_IFLAG: iflag_nxt = iflag_r & ~(wb_dat_i[NM-1:0] & {NM{wb_sel_i[0]}});
        `MBP_OFF_TCTL: tctl_nxt = wval[3:0];
        `MBP_OFF_TC: tc_nxt = wval;
        `MBP_OFF_PLIM: plim_nxt = wval;
        `MBP_OFF_MCTL: mact_nxt = wval[3*NM-1:0];
        `MBP_OFF_CCTL: begin
          cmode_nxt = mbp_cmode_t'(wval[`MBP_CCTL_MODE +: 2]);
          csel_nxt = wval[`MBP_CCTL_SEL +: CSW];
        end
        `MBP_OFF_PCTL: begin
          dbl_nxt = wval[`MBP_PCTL_DBL +: NO-1];
          oe_nxt = wval[`MBP_PCTL_OE +: NO];
        end
        `MBP_OFF_REL: rel_nxt = rel_nxt | wval[NM-1:0];
        default: begin
          if (widx >= 0) begin
            mr_shd_nxt[widx] = wval;
          end
        end
      endcase
    end
    if (tctl_r[`MBP_TCTL_RST]) begin
      tc_nxt = 32'h0;
      pc_nxt = 32'h0;
    end
    if (stop_hit) begin
      tctl_nxt[`MBP_TCTL_EN] = 1'b0;
    end
    // A match in the same cycle as the clearing write keeps its flag.
    iflag_nxt = iflag_nxt | (match_w & irq_v);
    pwm_nxt = pwm_on ? (lvl_w & oe_r) : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= `MBP_RST_WORD;
      iflag_r <= '0;
      tctl_r <= '0;
      tc_r <= `MBP_RST_WORD;
      plim_r <= `MBP_RST_WORD;
      pc_r <= `MBP_RST_WORD;
      mact_r <= '0;
      cmode_r <= MBP_TIMER;
      csel_r <= '0;
      dbl_r <= '0;
      oe_r <= '0;
      rel_r <= '0;
      pwm_r <= '0;
      for (int i = 0; i < NM; i++) begin
        mr_shd_r[i] <= `MBP_RST_WORD;
        mr_act_r[i] <= `MBP_RST_WORD;
      end
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      iflag_r <= iflag_nxt;
      tctl_r <= tctl_nxt;
      tc_r <= tc_nxt;
      plim_r <= plim_nxt;
      pc_r <= pc_nxt;
      mact_r <= mact_nxt;
      cmode_r <= cmode_nxt;
      csel_r <= csel_nxt;
      dbl_r <= dbl_nxt;
      oe_r <= oe_nxt;
      rel_r <= rel_nxt;
      pwm_r <= pwm_nxt;
      mr_shd_r <= mr_shd_nxt;
      mr_act_r <= mr_act_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign pwm_o = pwm_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  period_reset_a: assert property ((pwm_on && match_w[0] && !tc_wr) |=> tc_r == 32'h0)
    else $error("period match did not restart the counter");
  out1_rise_a: assert property (
      (pwm_on && oe_r[0] && match_w[0] && !match_w[1] && mr_act_r[1] != 32'h0 && !bus_wr)
      |=> ##1 pwm_o[0])
    else $error("single edge output did not rise at cycle start");
  out1_fall_a: assert property ((pwm_on && match_w[1] && !bus_wr) |=> ##1 !pwm_o[0])
    else $error("single edge output did not fall at its match");
  const_low_a: assert property (
      (pwm_on && !dbl_r[2] && mr_act_r[2] == 32'h0) |=> !$rose(lvl_w[1]))
    else $error("constant low output was driven high");
  dbl_rise_a: assert property (
      (pwm_on && dbl_r[3] && match_w[2] && !match_w[3]) |=> lvl_w[2])
    else $error("double edge output missed its rising edge");
  dbl_fall_a: assert property ((pwm_on && dbl_r[3] && match_w[3]) |=> !lvl_w[2])
    else $error("double edge output missed its falling edge");
  no_pwm_out_a: assert property (!pwm_on |=> pwm_o == '0)
    else $error("outputs driven outside PWM mode");
  release_hold_a: assert property (
      (pwm_on && $past(pwm_on) && !match_w[0]) |=> mr_act_r[1] == $past(mr_act_r[1]))
    else $error("active match changed away from cycle start");
  release_load_a: assert property (
      (pwm_on && match_w[0] && rel_r[1] && !bus_wr)
      |=> mr_act_r[1] == $past(mr_shd_r[1]) && !rel_r[1])
    else $error("released match value was not applied");
  stop_on_match_a: assert property (stop_hit |=> !tctl_r[`MBP_TCTL_EN])
    else $error("stop on match left the counter enabled");
  prescale_hold_a: assert property (
      (!tick && !tc_wr && !tctl_r[`MBP_TCTL_RST]) |=> $stable(tc_r))
    else $error("counter moved without a prescaler tick");
  flag_set_a: assert property (
      (|(match_w & irq_v)) |=> (iflag_r & $past(match_w & irq_v)) == $past(match_w & irq_v))
    else $error("match flag not set");
  bus_ack_a: assert property (ack_r |=> !ack_r)
    else $error("acknowledge lasted more than one cycle");

  wrap_c: cover property (pwm_on && match_w[0] ##[1:50] match_w[0]);
  dbl_pulse_c: cover property (dbl_r[3] && $rose(lvl_w[2]) ##[1:50] $fell(lvl_w[2]));
  release_c: cover property (pwm_on && match_w[0] && rel_r[1]);
  stop_c: cover property (stop_hit);
endmodule

// *** hdl/mbp_defs.svh ***
`ifndef MBP_DEFS_SVH
`define MBP_DEFS_SVH
`define MBP_OFF_IFLAG 8'h00
`define MBP_OFF_TCTL 8'h04
`define MBP_OFF_TC 8'h08
`define MBP_OFF_PLIM 8'h0c
`define MBP_OFF_PCNT 8'h10
`define MBP_OFF_MCTL 8'h14
`define MBP_OFF_MR0 8'h18
`define MBP_OFF_CCTL 8'h34
`define MBP_OFF_PCTL 8'h38
`define MBP_OFF_REL 8'h3c
`define MBP_TCTL_EN 0
`define MBP_TCTL_RST 1
`define MBP_TCTL_PWM 3
`define MBP_CCTL_MODE 0
`define MBP_CCTL_SEL 2
`define MBP_PCTL_DBL 2
`define MBP_PCTL_OE 9
`define MBP_NUM_MATCH 7
`define MBP_NUM_OUT 6
`define MBP_RST_WORD 32'h0000_0000
`endif

// *** hdl/mbp_pkg.sv ***
package mbp_pkg;
  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } mbp_mact_t;
  typedef enum logic [1:0] {
    MBP_TIMER,
    MBP_CNT_RISE,
    MBP_CNT_FALL,
    MBP_CNT_BOTH
  } mbp_cmode_t;
endpackage

// *** hdl/mbp_cnt_src.sv ***
`timescale 1ns/1ps
module mbp_cnt_src import mbp_pkg::*; #(
  parameter int NCAP = 2,
  parameter int CSW = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NCAP-1:0] cap_i,
  input wire mbp_cmode_t mode_i,
  input wire logic [CSW-1:0] sel_i,
  output logic cnt_ev_o
);
  logic [NCAP-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic ev_r, ev_nxt;

  // A new level is accepted only once the second and third stages agree.
  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < NCAP; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
    case (mode_i)
      MBP_TIMER: ev_nxt = 1'b1;
      MBP_CNT_RISE: ev_nxt = lvl_nxt[sel_i] & ~lvl_r[sel_i];
      MBP_CNT_FALL: ev_nxt = ~lvl_nxt[sel_i] & lvl_r[sel_i];
      MBP_CNT_BOTH: ev_nxt = lvl_nxt[sel_i] ^ lvl_r[sel_i];
      default: ev_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      ev_r <= 1'b0;
    end else begin
      s1_r <= cap_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      ev_r <= ev_nxt;
    end
  end

  assign cnt_ev_o = ev_r;
endmodule

// *** hdl/mbp_pwm_chan.sv ***
`timescale 1ns/1ps
module mbp_pwm_chan import mbp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic period_ev_i,
  input wire logic set_ev_i,
  input wire logic clr_ev_i,
  input wire logic own_zero_i,
  input wire logic dbl_i,
  output logic level_o
);
  logic lvl_r, lvl_nxt;

  // The falling edge wins when both edges land on the same count.
  always_comb begin
    lvl_nxt = lvl_r;
    if (!run_i) begin
      lvl_nxt = 1'b0;
    end else if (dbl_i) begin
      if (clr_ev_i) begin
        lvl_nxt = 1'b0;
      end else if (set_ev_i) begin
        lvl_nxt = 1'b1;
      end
    end else begin
      if (clr_ev_i) begin
        lvl_nxt = 1'b0;
      end else if (period_ev_i && !own_zero_i) begin
        lvl_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
endmodule

// *** tb/mbp_load.sv ***
`timescale 1ns/1ps
module mbp_load (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [5:0] pwm_i,
  output logic [15:0] hi_o [6],
  output logic [15:0] rise_o [6]
);
  logic [5:0] prev_r;
  // The load integrates high time and rising edges, so a window of whole periods
  // gives the same totals whatever its phase against the cycle.
  always_ff @(posedge clk_i) begin
    prev_r <= pwm_i;
    for (int k = 0; k < 6; k++) begin
      if (clr_i) begin
        hi_o[k] <= 16'h0000;
        rise_o[k] <= 16'h0000;
      end else begin
        hi_o[k] <= hi_o[k] + 16'(pwm_i[k]);
        rise_o[k] <= rise_o[k] + 16'(pwm_i[k] & ~prev_r[k]);
      end
    end
  end
endmodule

// *** tb/mbp_pwm_timer_bench.sv ***
`timescale 1ns/1ps
`include "mbp_defs.svh"
module mbp_pwm_timer_bench;
  logic clk, rst, cyc, stb, we, clr, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic [1:0] cap;
  logic [5:0] pwm;
  logic [15:0] hi [6];
  logic [15:0] rise [6];
  int error_cnt, num_checks;
  int h [6] = '{4, 0, 6, 8, 5, 6};

  mbp_pwm_timer mbp_pwm_timer_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cap_i(cap), .pwm_o(pwm));
  mbp_load mbp_load_i (.clk_i(clk), .clr_i(clr), .pwm_i(pwm), .hi_o(hi), .rise_o(rise));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_wave(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t waveform count got %0d expected %0d", $time, got, exp);
    end
  endtask

  // Waits as long as the slave takes; only the watchdog ends a hung transfer.
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic meas(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge clk);
      cap[s] <= 1'b1;
      repeat (10) @(posedge clk);
      cap[s] <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {cyc, stb, we, clr} = 4'h0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    sel = 4'hf;
    cap = 2'h0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wbx(0, `MBP_OFF_TCTL, 0);
    chk_reg(q, 32'h0000_0000);
    wbx(0, `MBP_OFF_MR0, 0);
    chk_reg(q, 32'h0000_0000);
    wbx(0, 8'hfc, 0);
    chk_reg(q, 32'h0000_0000);
    $display("test reset done");
    // Plain timer: match one resets the count at four and flags.
    wbx(1, `MBP_OFF_MCTL, 32'h18);
    wbx(1, `MBP_OFF_MR0 + 8'h04, 32'h4);
    wbx(1, `MBP_OFF_PCTL, 32'h7e00);
    wbx(1, `MBP_OFF_TCTL, 32'h1);
    repeat (3) begin
      wbx(0, `MBP_OFF_TC, 0);
      chk_reg({31'h0, q <= 32'd4}, 32'h1);
    end
    meas(40);
    for (int k = 0; k < 6; k++) chk_wave(hi[k], 16'h0000);
    wbx(0, `MBP_OFF_IFLAG, 0);
    chk_reg(q, 32'h2);
    wbx(1, `MBP_OFF_TCTL, 32'h0);
    wbx(1, `MBP_OFF_IFLAG, 32'h2);
    wbx(0, `MBP_OFF_IFLAG, 0);
    chk_reg(q, 32'h0);
    wbx(1, `MBP_OFF_MCTL, 32'h28);
    wbx(1, `MBP_OFF_TC, 32'h0);
    wbx(1, `MBP_OFF_TCTL, 32'h1);
    repeat (20) @(posedge clk);
    wbx(0, `MBP_OFF_TCTL, 0);
    chk_reg(q, 32'h0);
    wbx(0, `MBP_OFF_IFLAG, 0);
    chk_reg(q, 32'h2);
    wbx(1, `MBP_OFF_IFLAG, 32'h2);
    wbx(1, `MBP_OFF_MCTL, 32'h0);
    wbx(1, `MBP_OFF_TCTL, 32'h3);
    wbx(0, `MBP_OFF_TC, 0);
    chk_reg(q, 32'h0);
    $display("test timer done");
    // Counter modes: rising, falling, both edges of input zero.
    for (int m = 1; m < 4; m++) begin
      wbx(1, `MBP_OFF_TCTL, 32'h0);
      wbx(1, `MBP_OFF_CCTL, 32'(m));
      wbx(1, `MBP_OFF_TC, 32'h0);
      wbx(1, `MBP_OFF_TCTL, 32'h1);
      pulse(0, 3);
      wbx(0, `MBP_OFF_TC, 0);
      chk_reg(q, (m == 3) ? 32'h6 : 32'h3);
    end
    wbx(1, `MBP_OFF_TCTL, 32'h0);
    wbx(1, `MBP_OFF_CCTL, 32'h5);
    wbx(1, `MBP_OFF_TC, 32'h0);
    wbx(1, `MBP_OFF_TCTL, 32'h1);
    pulse(0, 2);
    wbx(0, `MBP_OFF_TC, 0);
    chk_reg(q, 32'h0);
    pulse(1, 2);
    wbx(0, `MBP_OFF_TC, 0);
    chk_reg(q, 32'h2);
    wbx(1, `MBP_OFF_TCTL, 32'h0);
    wbx(1, `MBP_OFF_CCTL, 32'h0);
    $display("test counter done");
    // Period ten; outputs three and five double edged, five's pulse spanning the cycle start.
    wbx(1, `MBP_OFF_TC, 32'h0);
    for (int i = 0; i < 7; i++)
      wbx(1, `MBP_OFF_MR0 + 8'(4 * i), (i == 0) ? 32'd9 : 32'(h[i - 1] == 8 ? 7 :
        (i == 1 ? 3 : (i == 2 ? 0 : (i == 3 ? 6 : (i == 5 ? 2 : 5))))));
    wbx(1, `MBP_OFF_PCTL, 32'h7e28);
    wbx(1, `MBP_OFF_REL, 32'h7f);
    wbx(1, `MBP_OFF_TCTL, 32'h9);
    repeat (30) @(posedge clk);
    meas(100);
    for (int k = 0; k < 6; k++) begin
      chk_wave(hi[k], 16'(10 * h[k]));
      chk_wave(rise[k], (h[k] != 0) ? 16'd10 : 16'd0);
    end
    $display("test pwm done");
    wbx(1, `MBP_OFF_MR0 + 8'h04, 32'd5);
    meas(100);
    chk_wave(hi[0], 16'd40);
    wbx(1, `MBP_OFF_REL, 32'h2);
    repeat (20) @(posedge clk);
    meas(100);
    chk_wave(hi[0], 16'd60);
    $display("test release done");
    wbx(1, `MBP_OFF_PLIM, 32'h1);
    repeat (40) @(posedge clk);
    meas(200);
    chk_wave(rise[0], 16'd10);
    chk_wave(hi[0], 16'd120);
    $display("test prescale done");
    end_of_test();
  end
endmodule
